// ---- src/sfp_regs.vh ----
// sfp_regs.vh - constants of the serial flash command engine:
// opcodes, widths, erased value and counter limits.
// assumes it is included by bare name; holds definitions only.
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFP_OP_READ_FAST  8'h0B
`define SFP_OP_READ_SLOW  8'h03
`define SFP_OP_READ_DUAL  8'h3B
`define SFP_OP_PROGRAM    8'h02
`define SFP_OP_PAGE_ERASE 8'h81

// ----------------------------------------------------------------
// widths and values
// ----------------------------------------------------------------
`define SFP_ADDR_W        17
`define SFP_PAGE_W        9
`define SFP_ERASED        8'hFF
`define SFP_FIFO_W        8
`define SFP_FIFO_DEPTH    4
`define SFP_PBUF_DEPTH    256

// ----------------------------------------------------------------
// counter limits
// ----------------------------------------------------------------
`define SFP_BIT_LAST      3'h7
`define SFP_BIT_FIRST     3'h0
`define SFP_ABYTE_LAST    2'h2
`define SFP_IDX_LAST      8'hFF
`define SFP_SHIFT_SINGLE  3'h7
`define SFP_SHIFT_DUAL    3'h3

`endif

// ---- src/sfp_fifo.v ----
// sfp_fifo.v - small synchronous fifo with valid/ready on both sides.
// assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module sfp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             flush,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wp_r;
	reg [AW-1:0]    rp_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rp_r];

	// storage has no reset; only pointers and count need a defined value
	always @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	// pointers wrap naturally since depth is a power of two
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else if (flush) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // sfp_fifo

// ---- src/sfp_page_buf.v ----
// sfp_page_buf.v - 256-byte page buffer, one write and one read port.
// assumes one clock; read data appear one edge after rd_en.
`timescale 1ns/1ps
`include "sfp_regs.vh"
module sfp_page_buf (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire       rd_en,
	input  wire [7:0] rd_addr,
	output reg  [7:0] rd_data
);
	reg [7:0] mem_r [0:`SFP_PBUF_DEPTH-1];

	// write port
	always @(posedge clk) begin
		if (wr_en)
			mem_r[wr_addr] <= wr_data;
	end

	// registered read port
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_data <= `SFP_ERASED;
		else if (rd_en)
			rd_data <= mem_r[rd_addr];
	end
endmodule // sfp_page_buf

// ---- src/sfp_flash_engine.v ----
// sfp_flash_engine.v - command engine of a small spi serial flash:
// single/dual array read, byte/page program, page erase.
// assumes an array port outside (read data one edge after the array
// sees rd_en) and spi pins sampled by clk, far faster than sck.
//
// Overview of operation
// R1 - read accepted with fast or slow opcode, then three address bytes
// R2 - fast read needs one dummy byte after address, slow read none
// R3 - read data shifted out msb first, address counter auto-increments
// R4 - read address wraps from top of array to zero without pause
// R5 - chip select release ends read at any bit and floats output
// R6 - dual read: opcode, three address bytes, one dummy byte
// R7 - dual read gives two bits per clock, high bit on serial output
// R8 - chip select release floats both output and dual line
// R9 - program: opcode, address, data bytes into 256-byte page buffer
// R10 - program needs write latch flag; targets erased bytes
// R11 - data past page end wraps to start of same page
// R12 - more than 256 data bytes keeps only the last 256
// R13 - on release buffered bytes are written; unloaded bytes stay erased
// R14 - abort unless full address, one data byte, byte-aligned release
// R15 - protected target: program not executed, back to idle
// R16 - write latch flag cleared whenever a program aborts
// R17 - busy while program runs; write latch flag cleared before end
// R18 - host should poll status rather than wait worst-case time
// R19 - each programmed byte verified; failure sets error flag
// R20 - page erase: opcode, then page bit 8, bits 7..0, dummy byte
// R21 - on release the page is erased to ones, busy until done
// R22 - erase verified; any failing byte sets error flag
// R23 - input sampled on rising sck edge, output changed on falling
// R24 - unknown opcode ignored until chip select cycles; early release idles
// R25 - address bits 23 to 17 ignored
// R26 - erase needs latch flag, aligned release, unprotected; latch cleared
`timescale 1ns/1ps
`include "sfp_regs.vh"
module sfp_flash_engine (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        cs_n,
	input  wire        sck,
	input  wire        dual_data_line_in,
	output reg         so_out,
	output reg         so_oe,
	output reg         dual_data_line_out,
	output reg         dual_data_line_oe,
	input  wire        write_latch_set,
	input  wire        write_latch_clr,
	input  wire        protect_en,
	input  wire        err_clr,
	output reg         write_latch_flag,
	output reg         program_erase_error_flag,
	output reg         busy,
	output reg  [16:0] arr_addr,
	output reg         arr_rd_en,
	input  wire [7:0]  arr_rd_data,
	output reg         arr_wr_en,
	output reg  [7:0]  arr_wr_data
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam S_IDLE   = 13'h0001;
	localparam S_CMD    = 13'h0002;
	localparam S_ADDR   = 13'h0004;
	localparam S_DUMMY  = 13'h0008;
	localparam S_RDATA  = 13'h0010;
	localparam S_PDATA  = 13'h0020;
	localparam S_ERASE  = 13'h0040;
	localparam S_IGNORE = 13'h0080;
	localparam S_CBUF   = 13'h0100;
	localparam S_CWR    = 13'h0200;
	localparam S_CRD    = 13'h0400;
	localparam S_CWAIT  = 13'h0800;
	localparam S_CCMP   = 13'h1000;

	// command kinds, one-hot
	localparam K_NONE  = 5'h00;
	localparam K_SLOW  = 5'h01;
	localparam K_FAST  = 5'h02;
	localparam K_DUAL  = 5'h04;
	localparam K_PROG  = 5'h08;
	localparam K_ERASE = 5'h10;

	function [4:0] op_kind;
		input [7:0] op;
		begin
			case (op)
			`SFP_OP_READ_SLOW:  op_kind = K_SLOW;
			`SFP_OP_READ_FAST:  op_kind = K_FAST;
			`SFP_OP_READ_DUAL:  op_kind = K_DUAL;
			`SFP_OP_PROGRAM:    op_kind = K_PROG;
			`SFP_OP_PAGE_ERASE: op_kind = K_ERASE;
			default:            op_kind = K_NONE;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers: {cs_n, sck, data line}
	// ----------------------------------------------------------------
	wire [2:0] pin_raw;
	reg  [2:0] s1_r;
	reg  [2:0] s2_r;
	reg  [2:0] s3_r;
	assign pin_raw = {cs_n, sck, dual_data_line_in};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			// idle levels: cs high, sck low, data low
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r[gi] <= (gi == 2);
					s2_r[gi] <= (gi == 2);
					s3_r[gi] <= (gi == 2);
				end else begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
				end
			end
		end
	endgenerate

	wire cs_fall  = ~s2_r[2] & s3_r[2];
	wire cs_rise  = s2_r[2] & ~s3_r[2];
	wire sck_rise = s2_r[1] & ~s3_r[1] & ~s2_r[2];   // R23
	wire sck_fall = ~s2_r[1] & s3_r[1] & ~s2_r[2];   // R23
	wire si_s     = s2_r[0];

	// ----------------------------------------------------------------
	// engine registers
	// ----------------------------------------------------------------
	reg [12:0]  st_r;
	reg [4:0]   kind_r;
	reg [6:0]   sr_r;
	reg [2:0]   bit_r;
	reg [1:0]   abyte_r;
	reg [23:0]  addr_r;
	reg         got_r;
	reg [255:0] loaded_r;
	reg [8:0]   page_r;
	reg [7:0]   idx_r;
	reg [7:0]   wdat_r;
	reg         wl_drop_r;
	reg         err_set_r;
	reg [16:0]  pf_addr_r;
	reg         p1_r;
	reg         p2_r;
	reg [7:0]   osr_r;
	reg [2:0]   ocnt_r;

	wire       byte_done = sck_rise & (bit_r == `SFP_BIT_LAST);
	wire [7:0] new_byte  = {sr_r, si_s};
	wire       in_frame  = |(st_r & (S_CMD | S_ADDR | S_DUMMY | S_RDATA |
	                       S_PDATA | S_ERASE | S_IGNORE));
	wire       aligned   = (bit_r == `SFP_BIT_FIRST);
	wire       modifying = |(kind_r & (K_PROG | K_ERASE)) &
	                       |(st_r & (S_ADDR | S_PDATA | S_ERASE));
	wire       exec_prog = st_r[5] & got_r & aligned &
	                       write_latch_flag & ~protect_en;   // R10 R14 R15
	wire       exec_era  = st_r[6] & aligned &
	                       write_latch_flag & ~protect_en;   // R26
	wire       is_dual   = kind_r[2];

	// page buffer hookup: write during data phase, read during commit
	wire       pb_wr = st_r[5] & byte_done;
	wire [7:0] pb_q;

	sfp_page_buf u_pbuf (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (pb_wr),
		.wr_addr (addr_r[7:0]),
		.wr_data (new_byte),
		.rd_en   (st_r[8]),
		.rd_addr (idx_r),
		.rd_data (pb_q)
	);

	// prefetch fifo decouples array latency from sck timing
	wire       pf_active = st_r[3] | st_r[4];
	wire       ff_in_ready;
	wire       ff_out_valid;
	wire [7:0] ff_out_data;
	wire       ff_pop = st_r[4] & sck_fall & (ocnt_r == 3'h0);
	// an empty fifo gives erased bits for the whole byte, never stale ones
	wire [7:0] out_byte = ff_out_valid ? ff_out_data : `SFP_ERASED;

	sfp_fifo #(
		.WIDTH (`SFP_FIFO_W),
		.DEPTH (`SFP_FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.flush     (cs_rise | cs_fall),
		.in_valid  (p2_r & pf_active),
		.in_ready  (ff_in_ready),
		.in_data   (arr_rd_data),
		.out_valid (ff_out_valid),
		.out_ready (ff_pop),
		.out_data  (ff_out_data)
	);

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	// a frame opened while busy is dropped whole: only idle acts on its cs fall
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= S_IDLE;
			kind_r    <= K_NONE;
			sr_r      <= 7'h00;
			bit_r     <= `SFP_BIT_FIRST;
			abyte_r   <= 2'h0;
			addr_r    <= 24'h000000;
			got_r     <= 1'b0;
			loaded_r  <= {256{1'b0}};
			page_r    <= 9'h000;
			idx_r     <= 8'h00;
			wdat_r    <= `SFP_ERASED;
			wl_drop_r <= 1'b0;
			err_set_r <= 1'b0;
		end else begin
			wl_drop_r <= 1'b0;
			err_set_r <= 1'b0;
			if (sck_rise & in_frame) begin
				sr_r  <= new_byte[6:0];
				bit_r <= bit_r + 3'h1;
			end
			case (1'b1)
			st_r[0]: begin
				if (cs_fall) begin
					st_r  <= S_CMD;
					bit_r <= `SFP_BIT_FIRST;
				end
			end
			st_r[1]: begin
				if (byte_done) begin
					kind_r  <= op_kind(new_byte);
					abyte_r <= 2'h0;
					got_r   <= 1'b0;
					loaded_r <= {256{1'b0}};
					st_r    <= (op_kind(new_byte) == K_NONE) ?
					           S_IGNORE : S_ADDR;   // R24
				end
			end
			st_r[2]: begin
				if (byte_done) begin
					addr_r  <= {addr_r[15:0], new_byte};
					abyte_r <= abyte_r + 2'h1;
					if (abyte_r == `SFP_ABYTE_LAST) begin
						case (1'b1)
						kind_r[0]: st_r <= S_RDATA;  // R1
						kind_r[3]: st_r <= S_PDATA;  // R9
						kind_r[4]: st_r <= S_ERASE;  // R20
						default:   st_r <= S_DUMMY;  // R2 R6
						endcase
					end
				end
			end
			st_r[3]: begin
				if (byte_done)
					st_r <= S_RDATA;
			end
			st_r[5]: begin
				// page index wraps in 8 bits, overwriting older bytes
				if (byte_done) begin
					loaded_r[addr_r[7:0]] <= 1'b1;          // R13
					addr_r[7:0] <= addr_r[7:0] + 8'h01;     // R11 R12
					got_r <= 1'b1;
				end
			end
			st_r[8]: st_r <= S_CWR;
			st_r[9]: begin
				if (kind_r[3] & ~loaded_r[idx_r]) begin
					st_r <= S_CCMP;   // R13
				end else begin
					wdat_r <= kind_r[4] ? `SFP_ERASED : pb_q;   // R21
					st_r   <= S_CRD;
				end
			end
			st_r[10]: st_r <= S_CWAIT;
			st_r[11]: st_r <= S_CCMP;
			st_r[12]: begin
				// verify only bytes actually written
				if ((kind_r[4] | loaded_r[idx_r]) &
				    (arr_rd_data != wdat_r))
					err_set_r <= 1'b1;   // R19 R22
				idx_r <= idx_r + 8'h01;
				if (idx_r == `SFP_IDX_LAST) begin
					wl_drop_r <= 1'b1;   // R17 R26
					st_r      <= S_IDLE;
				end else begin
					st_r <= S_CBUF;
				end
			end
			default: ;
			endcase
			// release closes every frame; only a complete one commits
			if (cs_rise & in_frame) begin
				if (exec_prog | exec_era) begin
					st_r   <= S_CBUF;   // R13 R21
					page_r <= addr_r[16:8];   // R25
					idx_r  <= 8'h00;
				end else begin
					st_r <= S_IDLE;   // R5 R15 R24
					if (modifying)
						wl_drop_r <= 1'b1;   // R16 R26
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// status flags: a set in the clearing cycle wins
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_latch_flag         <= 1'b0;
			program_erase_error_flag <= 1'b0;
			busy                     <= 1'b0;
		end else begin
			write_latch_flag <= write_latch_set |
			    (write_latch_flag & ~(write_latch_clr | wl_drop_r));
			program_erase_error_flag <= err_set_r |
			    (program_erase_error_flag & ~err_clr);
			busy <= |(st_r & (S_CBUF | S_CWR | S_CRD | S_CWAIT |
			        S_CCMP));   // R17 R21
		end
	end

	// ----------------------------------------------------------------
	// array port: prefetch during reads, write/verify during commit
	// ----------------------------------------------------------------
	// issue only when fifo has room and nothing is in flight, so a
	// returning byte always finds a free slot
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arr_addr    <= {`SFP_ADDR_W{1'b0}};
			arr_rd_en   <= 1'b0;
			arr_wr_en   <= 1'b0;
			arr_wr_data <= `SFP_ERASED;
			pf_addr_r   <= {`SFP_ADDR_W{1'b0}};
			p1_r        <= 1'b0;
			p2_r        <= 1'b0;
		end else begin
			arr_rd_en <= 1'b0;
			arr_wr_en <= 1'b0;
			p2_r      <= p1_r;
			p1_r      <= 1'b0;
			if (st_r[2] & byte_done & (abyte_r == `SFP_ABYTE_LAST))
				pf_addr_r <= {addr_r[8:0], new_byte};   // R25
			if (pf_active & ~cs_rise & ff_in_ready & ~p1_r & ~p2_r) begin
				arr_addr  <= pf_addr_r;
				arr_rd_en <= 1'b1;
				p1_r      <= 1'b1;
				pf_addr_r <= pf_addr_r + 17'h00001;   // R3 R4
			end
			if (st_r[9] & (kind_r[4] | loaded_r[idx_r])) begin
				arr_addr    <= {page_r, idx_r};
				arr_wr_en   <= 1'b1;
				arr_wr_data <= kind_r[4] ? `SFP_ERASED : pb_q;
			end
			if (st_r[10])
				arr_rd_en <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// serial output shifter, changes on falling sck
	// ----------------------------------------------------------------
	// an empty fifo at a byte start reads as erased; at the bench
	// sck rate the first byte lands long before it is needed
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			so_out             <= 1'b0;
			so_oe              <= 1'b0;
			dual_data_line_out <= 1'b0;
			dual_data_line_oe  <= 1'b0;
			osr_r              <= 8'h00;
			ocnt_r             <= 3'h0;
		end else if (cs_rise | ~st_r[4]) begin
			so_oe             <= 1'b0;   // R5 R8
			dual_data_line_oe <= 1'b0;   // R8
			ocnt_r            <= 3'h0;
		end else if (sck_fall) begin
			so_oe             <= 1'b1;
			dual_data_line_oe <= is_dual;   // R7
			if (ocnt_r == 3'h0) begin
				so_out             <= out_byte[7];   // R3
				dual_data_line_out <= out_byte[6];   // R7
				ocnt_r <= is_dual ? `SFP_SHIFT_DUAL : `SFP_SHIFT_SINGLE;
				if (is_dual)
					osr_r <= {out_byte[5:0], 2'b00};
				else
					osr_r <= {out_byte[6:0], 1'b0};
			end else begin
				so_out             <= osr_r[7];
				dual_data_line_out <= osr_r[6];
				osr_r  <= is_dual ? {osr_r[5:0], 2'b00} :
				                    {osr_r[6:0], 1'b0};
				ocnt_r <= ocnt_r - 3'h1;
			end
		end
	end
endmodule // sfp_flash_engine

// ---- tb/sfp_flash_engine_asserts.sv ----
// sfp_flash_engine_asserts.sv - pin-level checks of the flash engine.
// assumes it is bound to sfp_flash_engine, clk far faster than sck.
`timescale 1ns/1ps
module sfp_flash_engine_asserts (
	input wire        clk,
	input wire        rst_n,
	input wire        cs_n,
	input wire        sck,
	input wire        so_out,
	input wire        so_oe,
	input wire        dual_data_line_oe,
	input wire        write_latch_set,
	input wire        err_clr,
	input wire        write_latch_flag,
	input wire        program_erase_error_flag,
	input wire        busy,
	input wire [16:0] arr_addr,
	input wire        arr_rd_en,
	input wire        arr_wr_en
);
	reg [10:0] busy_cnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// length of a self-timed walk; a stuck busy would hang the host
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			busy_cnt_r <= 11'h000;
		else
			busy_cnt_r <= busy ? busy_cnt_r + 11'h001 : 11'h000;
	end

	// ------------------------------------------------------------
	// sequences and properties
	// ------------------------------------------------------------
	sequence s_cs_idle;
		cs_n [*6];
	endsequence
	sequence s_wr_then_rd;
		arr_wr_en ##1 (arr_rd_en && $stable(arr_addr));
	endsequence
	property p_so_float;
		s_cs_idle |-> !so_oe;
	endproperty
	a_so_float: assert property (p_so_float)
		else $error("serial output driven while deselected");
	property p_dual_float;
		s_cs_idle |-> !dual_data_line_oe;
	endproperty
	a_dual_float: assert property (p_dual_float)
		else $error("dual line driven while deselected");
	property p_dual_pair;
		dual_data_line_oe |-> so_oe;
	endproperty
	a_dual_pair: assert property (p_dual_pair)
		else $error("dual line driven without serial output");
	property p_out_on_fall;
		so_oe && $past(so_oe) && $changed(so_out) |-> !sck && !$past(sck);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("output changed outside the low clock phase");
	property p_wr_busy;
		arr_wr_en |-> busy;
	endproperty
	a_wr_busy: assert property (p_wr_busy)
		else $error("array write outside busy");
	property p_verify;
		arr_wr_en |-> s_wr_then_rd;
	endproperty
	a_verify: assert property (p_verify)
		else $error("written byte not read back");
	property p_err_sticky;
		program_erase_error_flag && !err_clr |=> program_erase_error_flag;
	endproperty
	a_err_sticky: assert property (p_err_sticky)
		else $error("error flag lost");
	property p_latch_set;
		write_latch_set |=> write_latch_flag;
	endproperty
	a_latch_set: assert property (p_latch_set)
		else $error("latch flag not set");
	property p_end_latch;
		$fell(busy) && !$past(write_latch_set) |-> !write_latch_flag;
	endproperty
	a_end_latch: assert property (p_end_latch)
		else $error("latch flag still set after busy");
	property p_busy_len;
		busy_cnt_r < 11'h640;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy too long");
endmodule // sfp_flash_engine_asserts

bind sfp_flash_engine sfp_flash_engine_asserts u_sfp_flash_engine_asserts (
	.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .so_out(so_out),
	.so_oe(so_oe), .dual_data_line_oe(dual_data_line_oe),
	.write_latch_set(write_latch_set), .err_clr(err_clr),
	.write_latch_flag(write_latch_flag),
	.program_erase_error_flag(program_erase_error_flag), .busy(busy),
	.arr_addr(arr_addr), .arr_rd_en(arr_rd_en), .arr_wr_en(arr_wr_en));

// ---- tb/sfp_spi_host.sv ----
// sfp_spi_host.sv - spi host model, mode 0, sck period 16 clk.
// assumes the bench calls its tasks; idle sck stays low.
`timescale 1ns/1ps
module sfp_spi_host (
	input  wire clk,
	input  wire so_out,
	input  wire dev_d,
	input  wire dev_oe,
	output reg  cs_n = 1'b1,
	output reg  sck = 1'b0,
	output wire line
);
	reg mo_r = 1'b0;
	reg drv_r = 1'b0;
	reg junk_r = 1'b0;

	// a released line wanders so a stale bit never passes for data
	always @(posedge clk) junk_r <= ~junk_r;
	assign line = dev_oe ? dev_d : (drv_r ? mo_r : junk_r);

	// open or close a frame, sck already low
	task automatic frame(input bit on);
		@(posedge clk);
		cs_n <= !on;
		drv_r <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// nb clocks: drive after the fall, sample just before the rise
	task automatic xfer(input [7:0] tx, input int nb, input bit dual,
		output [7:0] rx);
		int i;
		rx = 8'h00;
		for (i = 0; i < nb; i++) begin
			mo_r <= tx[7-i];
			drv_r <= !dual;
			repeat (8) @(posedge clk);
			rx = dual ? {rx[5:0], so_out, line} : {rx[6:0], so_out};
			sck <= 1'b1;
			repeat (8) @(posedge clk);
			sck <= 1'b0;
		end
	endtask
endmodule // sfp_spi_host

// ---- tb/sfp_flash_engine_tb.sv ----
// sfp_flash_engine_tb.sv - self-checking bench of the flash engine.
// assumes the host model and a behavioural array with registered read.
`timescale 1ns/1ps
`include "sfp_regs.vh"
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
	end \
end
module sfp_flash_engine_tb;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg        write_latch_set = 1'b0;
	reg        write_latch_clr = 1'b0;
	reg        protect_en = 1'b0;
	reg        err_clr = 1'b0;
	reg  [7:0] arr_rd_data = 8'hFF;
	reg        fault_r = 1'b0;
	reg [31:0] seed_r = 32'h00000061;
	reg  [7:0] mem [0:131071];
	reg  [7:0] ref_m [0:131071];
	int        error_cnt = 0;
	int        total_checks = 0;
	int        wr_cnt = 0;
	wire       cs_n, sck, si_line, so_out, so_oe, dl_out, dl_oe;
	wire       write_latch_flag, program_erase_error_flag, busy;
	wire       arr_rd_en, arr_wr_en;
	wire [16:0] arr_addr;
	wire [7:0] arr_wr_data;

	always #5 clk = ~clk;

	sfp_flash_engine u_sfp_flash_engine (.clk(clk), .rst_n(rst_n),
		.cs_n(cs_n), .sck(sck), .dual_data_line_in(si_line),
		.so_out(so_out), .so_oe(so_oe), .dual_data_line_out(dl_out),
		.dual_data_line_oe(dl_oe), .write_latch_set(write_latch_set),
		.write_latch_clr(write_latch_clr), .protect_en(protect_en),
		.err_clr(err_clr), .write_latch_flag(write_latch_flag),
		.program_erase_error_flag(program_erase_error_flag), .busy(busy),
		.arr_addr(arr_addr), .arr_rd_en(arr_rd_en),
		.arr_rd_data(arr_rd_data), .arr_wr_en(arr_wr_en),
		.arr_wr_data(arr_wr_data));
	// an undriven serial output shows the inverse of its last bit
	sfp_spi_host u_sfp_spi_host (.clk(clk),
		.so_out(so_oe ? so_out : !so_out),
		.dev_d(dl_out), .dev_oe(dl_oe), .cs_n(cs_n), .sck(sck),
		.line(si_line));

	// array: read answers one edge later; fault spoils stored bit 0
	always @(posedge clk) begin
		if (arr_rd_en)
			arr_rd_data <= mem[arr_addr];
		if (arr_wr_en) begin
			mem[arr_addr] <= arr_wr_data ^ {7'h00, fault_r};
			wr_cnt <= wr_cnt + 1;
		end
	end

	// ------------------------------------------------------------
	// expectation helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed_r = seed_r ^ (seed_r << 13);
		seed_r = seed_r ^ (seed_r >> 17);
		seed_r = seed_r ^ (seed_r << 5);
		return seed_r[7:0];
	endfunction
	function automatic logic [7:0] idx(input [7:0] s, input int i);
		return s + i[7:0];
	endfunction
	function automatic int exp_wr(input [7:0] op, input int n, input bit ok);
		if (!ok)
			return 0;
		return (op == `SFP_OP_PAGE_ERASE || n > 256) ? 256 : n;
	endfunction

	task automatic send(input [7:0] b);
		reg [7:0] r;
		u_sfp_spi_host.xfer(b, 8, 1'b0, r);
	endtask

	// read n bytes, then pb clocks cut short by deselect
	task automatic rd(input [7:0] op, input [23:0] a, input int n,
		input int pb);
		reg [7:0] r;
		reg [16:0] p;
		int i;
		bit dl;
		dl = (op == `SFP_OP_READ_DUAL);
		p = a[16:0];
		u_sfp_spi_host.frame(1'b1);
		send(op);
		send(a[23:16]);
		send(a[15:8]);
		send(a[7:0]);
		if (op != `SFP_OP_READ_SLOW)
			send(rnd());
		for (i = 0; i < n; i++) begin
			u_sfp_spi_host.xfer(rnd(), dl ? 4 : 8, dl, r);
			`CHK(r, ref_m[p])
			p = p + 17'h00001;
		end
		if (pb > 0)
			u_sfp_spi_host.xfer(rnd(), pb, dl, r);
		u_sfp_spi_host.frame(1'b0);
	endtask

	// program or erase frame, x stray clocks after the last byte;
	// x below zero cuts the frame before the last address byte
	task automatic mod(input [7:0] op, input [23:0] a, input int n,
		input int x, input bit wl, input bit pro);
		reg [7:0] d;
		reg [7:0] r;
		int i;
		int k;
		int w0;
		bit kn;
		bit ok;
		kn = (op == `SFP_OP_PROGRAM || op == `SFP_OP_PAGE_ERASE);
		ok = wl && !pro && kn && x == 0 && (op != `SFP_OP_PROGRAM || n > 0);
		@(posedge clk);
		write_latch_set <= wl;
		write_latch_clr <= !wl;
		err_clr <= 1'b1;
		protect_en <= pro;
		@(posedge clk);
		write_latch_set <= 1'b0;
		write_latch_clr <= 1'b0;
		err_clr <= 1'b0;
		w0 = wr_cnt;
		u_sfp_spi_host.frame(1'b1);
		send(op);
		send(a[23:16]);
		send(a[15:8]);
		if (x >= 0)
			send(a[7:0]);
		for (i = 0; i < 256 && ok && n == 0; i++)
			ref_m[{a[16:8], i[7:0]}] = `SFP_ERASED;
		for (i = 0; i < n; i++) begin
			d = rnd();
			send(d);
			if (ok)
				ref_m[{a[16:8], idx(a[7:0], i)}] = d;
		end
		if (x > 0)
			u_sfp_spi_host.xfer(rnd(), x, 1'b0, r);
		u_sfp_spi_host.frame(1'b0);
		`CHK(busy, ok)
		for (k = 0; k < 3000 && busy !== 1'b0; k++)
			@(posedge clk);
		`CHK(busy, 1'b0)
		`CHK(write_latch_flag, wl && !kn)
		`CHK(program_erase_error_flag, ok && fault_r)
		`CHK(wr_cnt - w0, exp_wr(op, n, ok))
		for (i = 0; i < 256 && !fault_r; i++)
			`CHK(mem[{a[16:8], i[7:0]}], ref_m[{a[16:8], i[7:0]}])
	endtask

	task results;
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog sized from roughly 53k cycles of expected traffic
	initial begin
		#900000;
		error_cnt++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		results;
	end

	// main sequence: random array, reads, then modifying frames with one slow read-back after the 3-byte program
	initial begin
		int i;
		for (i = 0; i < 131072; i++) begin
			mem[i] = rnd();
			ref_m[i] = mem[i];
		end
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`SFP_OP_READ_SLOW, {rnd(), rnd(), rnd()}, 3, 3);
		rd(`SFP_OP_READ_FAST, 24'h01FFFE, 3, 0);
		rd(`SFP_OP_READ_DUAL, 24'hFFFFFF, 3, 1);
		mod(`SFP_OP_PAGE_ERASE, 24'hFFA35C, 0, 0, 1'b1, 1'b0);
		mod(`SFP_OP_PROGRAM, 24'h01A3FE, 258, 0, 1'b1, 1'b0);
		mod(`SFP_OP_PAGE_ERASE, 24'h004400, 0, 0, 1'b1, 1'b0);
		mod(`SFP_OP_PROGRAM, 24'h0044FE, 3, 0, 1'b1, 1'b0);
		rd(`SFP_OP_READ_SLOW, 24'h0044FE, 3, 0);
		mod(`SFP_OP_PROGRAM, 24'h004410, 1, 0, 1'b0, 1'b0);
		mod(`SFP_OP_PROGRAM, 24'h004410, 1, 3, 1'b1, 1'b0);
		mod(`SFP_OP_PROGRAM, 24'h004410, 0, 0, 1'b1, 1'b0);
		mod(`SFP_OP_PROGRAM, 24'h004410, 2, 0, 1'b1, 1'b1);
		mod(`SFP_OP_PAGE_ERASE, 24'h004400, 0, 0, 1'b1, 1'b1);
		mod(`SFP_OP_PAGE_ERASE, 24'h004400, 0, 5, 1'b1, 1'b0);
		mod(`SFP_OP_PAGE_ERASE, 24'h004400, 0, -1, 1'b1, 1'b0);
		mod(8'h9F, 24'h004410, 2, 0, 1'b1, 1'b0);
		fault_r = 1'b1;
		mod(`SFP_OP_PROGRAM, 24'h000010, 2, 0, 1'b1, 1'b0);
		mod(`SFP_OP_PAGE_ERASE, 24'h000000, 0, 0, 1'b1, 1'b0);
		fault_r = 1'b0;
		results;
	end
endmodule // sfp_flash_engine_tb
